// ===== hdl/mcs_top.sv
`timescale 1ns/100ps
`include "mcs_map.svh"
// Function
// R1 - an odd count of one bits in a received maneuver word pulses the verify line to telemetry.
// R2 - the sender sets bit 6 so each word holds an odd number of ones.
// R3 - an even count sends no verify and the sender must resend the word.
// R4 - an all-ones word loaded during a turn or burn overflows at eleven ones and stops the event.
// R5 - the sender should not shift command bits while durations count out.
// R6 - only one turn-axis driver may be active at a time.
// R7 - the pitch-start driver is held off while a roll turn runs.
// R8 - the ignition driver is held off while a pitch or roll turn runs.
// R9 - until separation the launch inhibit holds off clock, end counter and rectifier drivers.
// R10 - until separation all relays but clear and verify are held reset.
// R11 - duration drivers and flip-flops stay inactive until the midcourse sequence starts.
// R12 - panel deploy fires on the deploy command or the separation timer.
// R13 - attitude power switches on from the power command or the arming switch.
// R14 - the parity count clears at each word start and is judged only at word end.
module mcs_top
   import mcs_pkg::*;
#(
   parameter int WORD_BITS = `MCS_WORD_BITS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // serial command from the decoder
   input wire logic quantitative_info_line,
   input wire logic cmd_bit_valid,
   input wire logic cmd_word_start,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // telemetry and drivers
   output logic telemetry_encoder_verify,
   output mcs_drv_t drv,
   output logic launch_inhibit,
   output logic relay_hold,
   output logic maneuver_inhibit,
   output logic panel_deploy_command,
   output logic attitude_control_power,
   output logic irq
);
   localparam logic [WORD_BITS-1:0] ALL_ONES = '1;

   // register state
   logic [3:0] ctrl_q, ctrl_d;
   logic [`MCS_IRQ_W-1:0] irq_q, irq_d, mask_q, mask_d;
   logic [WORD_BITS-1:0] sreg_q, sreg_d, word_q, word_d;
   localparam int NB_W = $clog2(WORD_BITS + 1);
   localparam logic [NB_W-1:0] LAST_BIT = NB_W'(WORD_BITS - 1);
   logic [NB_W-1:0] nbits_q, nbits_d;
   logic par_q, par_d, ovf_q, ovf_d;
   mcs_turn_t turn_q, turn_d;
   logic burn_q, burn_d, yaw_q, yaw_d;
   mcs_drv_t drv_d;
   logic verify_d, panel_d, acpwr_d, irq_d_out;
   // bus state
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, ardy_q, ardy_d;
   logic [3:0] ws_q, ws_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic wr_go;
   logic [7:0] cmd_pulse;
   logic word_done, sep, mc_on;

   assign sep = ctrl_q[`MCS_CTRL_SEP];
   assign mc_on = ctrl_q[`MCS_CTRL_MCINIT];

   // bus handshake; address and data may arrive in either order
   always_comb begin
      aw_d = aw_q;
      ws_d = ws_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && !aw_q && !bv_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb; // strobe kept with its data, the bus may move on
      end
      wr_go = aw_q && w_q && !bv_q;
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q == `MCS_CTRL_OFF || awa_q == `MCS_CMD_OFF ||
                 awa_q == `MCS_IRQ_OFF || awa_q == `MCS_MASK_OFF) ? 2'b00 : 2'b10;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end else if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = 2'b00;
         rd_d = 32'h0000_0000;
         if (s_axi_araddr == `MCS_CTRL_OFF) begin
            rd_d[3:0] = ctrl_q;
         end else if (s_axi_araddr == `MCS_STAT_OFF) begin
            rd_d[8:0] = {ovf_q, burn_q, yaw_q, turn_q, par_q, mc_on, sep};
         end else if (s_axi_araddr == `MCS_IRQ_OFF) begin
            rd_d[`MCS_IRQ_W-1:0] = irq_q;
         end else if (s_axi_araddr == `MCS_MASK_OFF) begin
            rd_d[`MCS_IRQ_W-1:0] = mask_q;
         end else if (s_axi_araddr == `MCS_WORD_OFF) begin
            rd_d[WORD_BITS-1:0] = word_q;
         end else if (s_axi_araddr != `MCS_CMD_OFF) begin
            rr_d = 2'b10;
         end
      end
      // readies registered one step ahead so every port leaves a flop
      awrdy_d = !aw_d && !bv_d;
      wrdy_d = !w_d && !bv_d;
      ardy_d = !rv_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         br_q <= 2'b00;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'b00;
         ws_q <= 4'h0;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         ardy_q <= 1'b1;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         ws_q <= ws_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         ardy_q <= ardy_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ardy_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // serial word intake, parity and overflow
   always_comb begin
      sreg_d = sreg_q;
      nbits_d = nbits_q;
      par_d = par_q;
      word_d = word_q;
      ovf_d = 1'b0;
      word_done = 1'b0;
      verify_d = 1'b0;
      if (cmd_word_start) begin
         sreg_d = '0; // [R14]
         nbits_d = '0;
         par_d = 1'b0;
      end else if (cmd_bit_valid) begin // [R5] not gated during a maneuver
         sreg_d = {sreg_q[WORD_BITS-2:0], quantitative_info_line};
         par_d = par_q ^ quantitative_info_line; // [R1]
         nbits_d = nbits_q + 1'b1;
         // all ones at the eleventh bit overflows the register
         if ({sreg_q[WORD_BITS-2:0], quantitative_info_line} == ALL_ONES &&
             nbits_q == LAST_BIT) begin
            ovf_d = 1'b1; // [R4]
         end
         if (nbits_q == LAST_BIT) begin
            word_done = 1'b1; // [R14] judged only at word end
            word_d = {sreg_q[WORD_BITS-2:0], quantitative_info_line};
            verify_d = par_q ^ quantitative_info_line; // [R1] [R3]
            nbits_d = '0;
         end
      end
   end

   // turn and burn tracking with interlocks
   always_comb begin
      turn_d = turn_q;
      burn_d = burn_q;
      yaw_d = yaw_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      cmd_pulse = 8'h00;
      if (wr_go && awa_q == `MCS_CTRL_OFF && ws_q[0]) begin
         ctrl_d = wd_q[3:0];
      end
      if (wr_go && awa_q == `MCS_MASK_OFF && ws_q[0]) begin
         mask_d = wd_q[`MCS_IRQ_W-1:0];
      end
      if (wr_go && awa_q == `MCS_CMD_OFF) begin
         cmd_pulse = wd_q[7:0];
      end
      // one axis at a time; a new axis command is dropped while another axis runs
      if (turn_q == MCS_IDLE && !yaw_q && mc_on) begin // [R6] [R11]
         if (cmd_pulse[`MCS_CMD_PITCH]) begin
            turn_d = MCS_PITCH;
         end else if (cmd_pulse[`MCS_CMD_ROLL]) begin
            turn_d = MCS_ROLL;
         end else if (cmd_pulse[`MCS_CMD_YAW]) begin
            yaw_d = 1'b1;
         end
      end
      if (cmd_pulse[`MCS_CMD_IGNITE] && mc_on && turn_q == MCS_IDLE) begin
         burn_d = 1'b1; // [R8]
      end
      if (cmd_pulse[`MCS_CMD_STOP] || ovf_q || !mc_on) begin
         turn_d = MCS_IDLE; // [R4] overflow stops the event
         yaw_d = 1'b0;
         burn_d = 1'b0;
      end
   end

   // drivers and clamps
   always_comb begin
      drv_d.turn_pitch = mc_on && turn_q == MCS_PITCH; // [R6] [R11]
      drv_d.turn_roll = mc_on && turn_q == MCS_ROLL;
      drv_d.turn_yaw = mc_on && yaw_q;
      drv_d.pitch_start = mc_on && turn_q == MCS_PITCH && turn_q != MCS_ROLL; // [R7]
      drv_d.motor_ignite = mc_on && burn_q && turn_q == MCS_IDLE; // [R8]
      panel_d = panel_deploy_command || (sep &&
         (cmd_pulse[`MCS_CMD_PANEL] || ctrl_q[`MCS_CTRL_TIMER])); // [R12] [R9]
      acpwr_d = attitude_control_power || cmd_pulse[`MCS_CMD_ACPWR] ||
         ctrl_q[`MCS_CTRL_ARM]; // [R13]
      irq_d = irq_q;
      if (wr_go && awa_q == `MCS_IRQ_OFF) begin
         irq_d = irq_q & ~wd_q[`MCS_IRQ_W-1:0];
      end
      // a set in the clearing cycle wins
      irq_d[`MCS_IRQ_VERIFY] = irq_d[`MCS_IRQ_VERIFY] | verify_d;
      irq_d[`MCS_IRQ_BADPAR] = irq_d[`MCS_IRQ_BADPAR] | (word_done && !verify_d); // [R3]
      irq_d[`MCS_IRQ_OVF] = irq_d[`MCS_IRQ_OVF] | ovf_d;
      irq_d_out = |(irq_d & mask_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `MCS_CTRL_RST;
         mask_q <= '0;
         irq_q <= '0;
         sreg_q <= '0;
         word_q <= '0;
         nbits_q <= '0;
         par_q <= 1'b0;
         ovf_q <= 1'b0;
         turn_q <= MCS_IDLE;
         burn_q <= 1'b0;
         yaw_q <= 1'b0;
         drv <= '0;
         telemetry_encoder_verify <= 1'b0;
         launch_inhibit <= 1'b1;
         relay_hold <= 1'b1;
         maneuver_inhibit <= 1'b1;
         panel_deploy_command <= 1'b0;
         attitude_control_power <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
         sreg_q <= sreg_d;
         word_q <= word_d;
         nbits_q <= nbits_d;
         par_q <= par_d;
         ovf_q <= ovf_d;
         turn_q <= turn_d;
         burn_q <= burn_d;
         yaw_q <= yaw_d;
         drv <= drv_d;
         telemetry_encoder_verify <= verify_d; // [R1]
         launch_inhibit <= !sep; // [R9]
         relay_hold <= !sep; // [R10]
         maneuver_inhibit <= !mc_on; // [R11]
         panel_deploy_command <= panel_d;
         attitude_control_power <= acpwr_d;
         irq <= irq_d_out;
      end
   end
endmodule

// ===== hdl/mcs_map.svh
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
// register byte offsets
`define MCS_CTRL_OFF 8'h00
`define MCS_CMD_OFF 8'h04
`define MCS_STAT_OFF 8'h08
`define MCS_IRQ_OFF 8'h0c
`define MCS_MASK_OFF 8'h10
`define MCS_WORD_OFF 8'h14
// ctrl field positions
`define MCS_CTRL_SEP 0
`define MCS_CTRL_MCINIT 1
`define MCS_CTRL_TIMER 2
`define MCS_CTRL_ARM 3
// cmd field positions (write-one pulses)
`define MCS_CMD_PITCH 0
`define MCS_CMD_ROLL 1
`define MCS_CMD_YAW 2
`define MCS_CMD_PSTART 3
`define MCS_CMD_IGNITE 4
`define MCS_CMD_STOP 5
`define MCS_CMD_PANEL 6
`define MCS_CMD_ACPWR 7
// irq bits
`define MCS_IRQ_VERIFY 0
`define MCS_IRQ_BADPAR 1
`define MCS_IRQ_OVF 2
`define MCS_IRQ_W 3
// word geometry and ctrl reset value
`define MCS_WORD_BITS 11
`define MCS_CTRL_RST 4'h0
`endif

// ===== hdl/mcs_pkg.sv
package mcs_pkg;
   typedef enum logic [2:0] {
      MCS_IDLE = 3'b001,
      MCS_PITCH = 3'b010,
      MCS_ROLL = 3'b100
   } mcs_turn_t;
   typedef struct packed {
      logic turn_pitch;
      logic turn_roll;
      logic turn_yaw;
      logic pitch_start;
      logic motor_ignite;
   } mcs_drv_t;
endpackage

// ===== tb/mcs_props.sv
`timescale 1ns/100ps
module mcs_props
   import mcs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched ports
   input wire logic cmd_bit_valid,
   input wire logic telemetry_encoder_verify,
   input wire mcs_drv_t drv,
   input wire logic launch_inhibit,
   input wire logic relay_hold,
   input wire logic maneuver_inhibit,
   input wire logic panel_deploy_command,
   input wire logic attitude_control_power
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // verify follows a sampled bit and drops again at once
   sequence s_bit_taken;
      $past(cmd_bit_valid);
   endsequence
   sequence s_pulse_over;
      ##1 !telemetry_encoder_verify;
   endsequence
   a_verify_pulse: assert property (telemetry_encoder_verify |-> s_bit_taken ##0 s_pulse_over)
      else $error("verify pulse without a bit or too long");
   a_axis_excl: assert property ($onehot0({drv.turn_pitch, drv.turn_roll, drv.turn_yaw}))
      else $error("two turn axes active");
   a_pstart_roll: assert property (drv.turn_roll |-> !drv.pitch_start)
      else $error("pitch start during roll");
   a_ignite_turn: assert property (drv.turn_pitch || drv.turn_roll |-> !drv.motor_ignite)
      else $error("ignition during turn");
   a_launch_pair: assert property (launch_inhibit == relay_hold)
      else $error("launch clamp and relay hold differ");
   a_clamp_drv: assert property (maneuver_inhibit |-> drv == 5'h00)
      else $error("driver active under maneuver clamp");
   a_panel_sep: assert property (panel_deploy_command |-> !launch_inhibit)
      else $error("panel deploy before separation");
   a_panel_stays: assert property (panel_deploy_command |=> panel_deploy_command)
      else $error("panel deploy dropped");
   a_power_stays: assert property (attitude_control_power |=> attitude_control_power)
      else $error("attitude power dropped");
endmodule

// ===== tb/mcs_ground_model.sv
`timescale 1ns/100ps
module mcs_ground_model (
   // clock
   input wire logic aclk,
   // serial command lines
   output logic quantitative_info_line,
   output logic cmd_bit_valid,
   output logic cmd_word_start
);
   // lines idle low until the first word
   initial begin
      quantitative_info_line = 1'h0;
      cmd_bit_valid = 1'h0;
      cmd_word_start = 1'h0;
   end
   // sends the first n bits msb first; good chooses odd or even parity
   // callers keep quiet while durations count out, except on purpose
   task automatic send_word(input logic [10:0] w, input bit good, input int n);
      logic [10:0] x;
      x = w;
      x[6] = good ^ (^{x[10:7], x[5:0]});
      @(posedge aclk);
      cmd_word_start <= 1'h1;
      for (int i = 10; i > 10 - n; i--) begin
         @(posedge aclk);
         cmd_word_start <= 1'h0;
         quantitative_info_line <= x[i];
         cmd_bit_valid <= 1'h1;
         @(posedge aclk);
         cmd_bit_valid <= 1'h0;
         quantitative_info_line <= ~x[i]; // no pull: stale data must not look valid
      end
   endtask
endmodule

// ===== tb/maneuver_command_safety_tb_top.sv
`timescale 1ns/100ps
module maneuver_command_safety_tb_top;
   import mcs_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, vld, start, line, ten;
   logic li, rh, mi, pd, acp, irq;
   logic [1:0] bresp, rresp;
   logic [10:0] w;
   mcs_drv_t drv;
   int failures = 0, tests_run = 0, vcnt = 0;
   logic [33:0] exp_q[$];
   always #12.5 aclk = ~aclk;
   // device and ground sender
   mcs_top dut_u (.aclk(aclk), .aresetn(aresetn), .quantitative_info_line(line),
      .cmd_bit_valid(vld), .cmd_word_start(start), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .telemetry_encoder_verify(ten), .drv(drv),
      .launch_inhibit(li), .relay_hold(rh), .maneuver_inhibit(mi),
      .panel_deploy_command(pd), .attitude_control_power(acp), .irq(irq));
   mcs_ground_model gnd_u (.aclk(aclk), .quantitative_info_line(line),
      .cmd_bit_valid(vld), .cmd_word_start(start));
   task chk(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // order: drv[4:0], launch, hold, maneuver clamp, panel, power, irq
   task outs(input logic [10:0] e);
      chk({23'h0, drv, li, rh, mi, pd, acp, irq}, {23'h0, e});
   endtask
   task close_out;
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one write; two extra edges let the register effects land
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      repeat (2) @(posedge aclk);
   endtask
   // read notes its expectation; the monitor compares
   task rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge aclk);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
   endtask
   // read data monitor and verify pulse counter
   always @(posedge aclk) begin
      if (rvalid === 1'h1 && rready === 1'h1) chk({rresp, rdata}, exp_q.pop_front());
      if (ten === 1'h1) vcnt++;
   end
   // main sequence
   initial begin
      void'($urandom(32'hf7d89bb4));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      outs(11'h038);
      rd(8'h00, 34'h0);
      rd(8'h18, {2'h2, 32'h0});
      wr(8'h04, 32'h41);
      outs(11'h038);
      wr(8'h00, 32'h1);
      outs(11'h008);
      wr(8'h04, 32'hc0);
      outs(11'h00e);
      wr(8'h00, 32'h3);
      wr(8'h04, 32'h02);
      wr(8'h04, 32'h18);
      outs(11'h206);
      wr(8'h04, 32'h20);
      wr(8'h04, 32'h10);
      outs(11'h046);
      wr(8'h04, 32'h04);
      wr(8'h04, 32'h01);
      outs(11'h146);
      wr(8'h04, 32'h20);
      wr(8'h04, 32'h11);
      outs(11'h486);
      gnd_u.send_word(11'h7ff, 1'h1, 11);
      repeat (3) @(posedge aclk);
      outs(11'h006);
      rd(8'h0c, 34'h5);
      wr(8'h0c, 32'h7);
      wr(8'h10, 32'h7);
      for (int i = 0; i < 4; i++) begin
         w = 11'($urandom());
         w[0] = 1'h0; // an all-ones word would also overflow
         w[6] = ~(^{w[10:7], w[5:0]});
         gnd_u.send_word(w, 1'h0, 11);
         gnd_u.send_word(w, 1'h0, 5);
         gnd_u.send_word(w, 1'h1, 11);
         repeat (3) @(posedge aclk);
         rd(8'h0c, 34'h3);
         rd(8'h14, 34'(w));
         outs(11'h007);
         wr(8'h10, 32'h0);
         outs(11'h006);
         wr(8'h0c, 32'h3);
         wr(8'h10, 32'h7);
         outs(11'h006);
      end
      chk(34'(vcnt), 34'h5);
      // second reset, then the timer and arming paths
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      outs(11'h038);
      wr(8'h00, 32'h5);
      outs(11'h00c);
      wr(8'h00, 32'h9);
      outs(11'h00e);
      close_out;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      close_out;
   end
endmodule
bind mcs_top mcs_props props_u (.aclk(aclk), .aresetn(aresetn), .cmd_bit_valid(cmd_bit_valid),
   .telemetry_encoder_verify(telemetry_encoder_verify), .drv(drv),
   .launch_inhibit(launch_inhibit), .relay_hold(relay_hold),
   .maneuver_inhibit(maneuver_inhibit), .panel_deploy_command(panel_deploy_command),
   .attitude_control_power(attitude_control_power));
